// ---- core/pilic_arb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pilic_defines.svh"
module pilic_arb
   import pilic_pkg::*;
(
   pilic_arb_if.arb bus // Level requests in, winning level out.
);
   logic [3:0] cand [0:2];
   logic [5:0] ord;
   logic [3:0] win;
   logic [1:0] g;

   // Returns {valid, level}; rev selects highest level number first in the group.
   function automatic logic [3:0] grp_pick(input logic [7:0] r, input int lo, input int hi,
                                          input logic rev);
      logic [3:0] res;
      int k;
      res = 4'h0;
      for (int i = 0; i < 3; i++) begin
         k = rev ? (hi - i) : (lo + i);
         if (k >= lo && k <= hi && r[k] && !res[3]) begin
            res = {1'b1, 3'(k)};
         end
      end
      return res;
   endfunction

   always_comb begin
      cand[0] = grp_pick(bus.lvl_req, 0, 1, bus.prio[`PIL_PRIO_SUBA]);
      cand[1] = grp_pick(bus.lvl_req, 2, 4, bus.prio[`PIL_PRIO_SUBB]);
      cand[2] = grp_pick(bus.lvl_req, 5, 7, bus.prio[`PIL_PRIO_SUBC]);
      // Group order, first group in the low two bits.
      unique case (bus.prio[`PIL_PRIO_ORD_LSB +: 3])
         3'd0: ord = {2'd2, 2'd1, 2'd0};
         3'd1: ord = {2'd1, 2'd2, 2'd0};
         3'd2: ord = {2'd2, 2'd0, 2'd1};
         3'd3: ord = {2'd0, 2'd2, 2'd1};
         3'd4: ord = {2'd1, 2'd0, 2'd2};
         3'd5: ord = {2'd0, 2'd1, 2'd2};
         default: ord = {2'd2, 2'd1, 2'd0};
      endcase
      win = 4'h0;
      g = 2'd0;
      for (int k = 2; k >= 0; k--) begin
         g = ord[k*2 +: 2];
         if (cand[g][3]) begin
            win = cand[g];
         end
      end
   end

   assign bus.win_valid = win[3];
   assign bus.win_lvl = win[2:0];
endmodule // pilic_arb
`default_nettype wire

// ---- core/pilic_arb_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pilic_arb_if;
   import pilic_pkg::*;
   pilic_lvl_vec_t lvl_req;
   logic [7:0] prio;
   logic win_valid;
   logic [2:0] win_lvl;
   modport arb (input lvl_req, input prio, output win_valid, output win_lvl);
   modport ctl (output lvl_req, output prio, input win_valid, input win_lvl);
endinterface
`default_nettype wire

// ---- core/pilic_ctrl.sv ----
// Functional notes
// - eight request levels, zero through seven.
// - level number is identifier, not priority.
// - priority register picks among active levels.
// - within level, lowest vector address wins.
// - grant disables interrupts, pushes PC, flags.
// - start address is two vector bytes.
// - vectors live in lowest 256 bytes.
// - execution starts at 0100H after reset.
// - global enable bit set, cleared, written.
// - per-level mask register; masked level ignored.
// - groups A 0-1, B 2-4, C 5-7.
// - read-only level pending bits.
// - pending cleared by hardware or software.
// - 26 sources, each own vector.
// - per-source enable also gates service.
// - reset clears global enable and neighbour.
// - mask bit n enables level n.
`timescale 1ns/1ps
`default_nettype none
`include "pilic_defines.svh"
module pilic_ctrl
   import pilic_pkg::*;
(
   input wire logic sys_clk, // Core clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic [25:0] src_pend, // Source pending bits from peripherals.
   input wire logic [25:0] src_en, // Source enable bits from peripherals.
   input wire logic sys_mode_wr, // Direct write strobe of system mode register.
   input wire logic [1:0] sys_mode_wdata, // Write data for system mode register.
   output logic [1:0] sys_mode_rdata, // System mode register contents.
   input wire logic enable_interrupts_instr, // Enable-interrupts instruction pulse.
   input wire logic disable_interrupts_instr, // Disable-interrupts instruction pulse.
   input wire logic lvl_mask_wr, // Write strobe of level mask register.
   input wire logic [7:0] lvl_mask_wdata, // Write data for level mask register.
   output logic [7:0] lvl_mask_rdata, // Level mask register contents.
   input wire logic lvl_prio_wr, // Write strobe of level priority register.
   input wire logic [7:0] lvl_prio_wdata, // Write data for level priority register.
   output logic [7:0] lvl_prio_rdata, // Level priority register contents.
   output logic [7:0] level_request, // Per-level pending bits, read only.
   output logic irq, // Request toward the core.
   input wire logic irq_ack, // Core grants the request.
   input wire logic [15:0] pc_cur, // Program counter at grant.
   input wire logic [7:0] flags_cur, // Status flags at grant.
   output logic stk_we, // Stack byte write strobe.
   output logic [7:0] stk_wdata, // Stack byte.
   output logic rom_re, // Program memory read strobe.
   output logic [15:0] rom_addr, // Program memory address.
   input wire logic [7:0] rom_rdata, // Program memory byte, one cycle after read.
   output logic [25:0] src_clr, // Pending clear pulses for self-clearing sources.
   output logic pc_load, // Load program counter pulse.
   output logic [15:0] pc_target, // Program counter value to load.
   output logic busy // Grant sequence in progress.
);
   localparam logic [44:0] LFIRST = `PIL_LVL_FIRST;

   pilic_state_t state_r;
   logic [1:0] system_mode_register_r;
   logic [7:0] level_mask_register_r;
   logic [7:0] level_priority_register_r;
   logic [25:0] pend_en;
   logic [7:0] level_pend;
   logic [7:0] act_lvl;
   logic gie;
   logic grant;
   logic [4:0] win_src;
   logic stk_we_r;
   logic [7:0] stk_wdata_r;
   logic rom_re_r;
   logic [15:0] rom_addr_r;
   logic [7:0] vec_r;
   logic [7:0] vec_hi_r;
   logic [15:0] pc_save_r;
   logic [7:0] flg_save_r;
   logic [25:0] src_clr_r;
   logic pc_load_r;
   logic [15:0] pc_target_r;

   pilic_arb_if arb_if ();

   pilic_arb u_arb (
      .bus(arb_if.arb)
   );

   assign pend_en = src_pend & src_en;

   for (genvar l = 0; l < `PIL_NUM_LVL; l++) begin : g_lvl
      localparam int LO = int'(LFIRST[l*5 +: 5]);
      localparam int HI = int'(LFIRST[(l+1)*5 +: 5]);
      assign level_pend[l] = |pend_en[HI-1:LO];
   end

   assign gie = system_mode_register_r[`PIL_SYM_GIE];
   assign act_lvl = level_pend & level_mask_register_r;
   assign arb_if.lvl_req = act_lvl;
   assign arb_if.prio = level_priority_register_r;
   // Arbitration is purely combinational, so every cycle shows the current winner.
   assign irq = (state_r == ST_IDLE) && gie && arb_if.win_valid;
   assign grant = irq && irq_ack;

   // Lowest source index in the level has the lowest vector address.
   function automatic logic [4:0] low_src(input logic [25:0] pe, input logic [2:0] lvl);
      logic [4:0] idx;
      int lo;
      int hi;
      idx = 5'h0;
      lo = int'(LFIRST[lvl*5 +: 5]);
      hi = int'(LFIRST[(lvl+1)*5 +: 5]);
      for (int s = 25; s >= 0; s--) begin
         if (s >= lo && s < hi && pe[s]) begin
            idx = 5'(s);
         end
      end
      return idx;
   endfunction

   assign win_src = low_src(pend_en, arb_if.win_lvl);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         system_mode_register_r <= `PIL_SYM_RST;
      end else begin
         if (sys_mode_wr) begin
            system_mode_register_r <= sys_mode_wdata;
         end
         if (enable_interrupts_instr) begin
            system_mode_register_r[`PIL_SYM_GIE] <= 1'b1;
         end
         if (disable_interrupts_instr) begin
            system_mode_register_r[`PIL_SYM_GIE] <= 1'b0;
         end
         if (grant) begin
            system_mode_register_r[`PIL_SYM_GIE] <= 1'b0;
         end
      end
   end

   // Mask writes while enabled are legal here; software keeps interrupts off around them.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         level_mask_register_r <= `PIL_MASK_RST;
         level_priority_register_r <= `PIL_PRIO_RST;
      end else begin
         if (lvl_mask_wr) begin
            level_mask_register_r <= lvl_mask_wdata;
         end
         if (lvl_prio_wr) begin
            level_priority_register_r <= lvl_prio_wdata;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         stk_we_r <= 1'b0;
         stk_wdata_r <= 8'h00;
         rom_re_r <= 1'b0;
         rom_addr_r <= 16'h0000;
         vec_r <= 8'h00;
         vec_hi_r <= 8'h00;
         pc_save_r <= 16'h0000;
         flg_save_r <= 8'h00;
         src_clr_r <= 26'h0;
         pc_load_r <= 1'b1;
         pc_target_r <= `PIL_RESET_PC;
      end else begin
         pc_load_r <= 1'b0;
         src_clr_r <= 26'h0;
         unique case (state_r)
            ST_IDLE: begin
               if (grant) begin
                  stk_we_r <= 1'b1;
                  stk_wdata_r <= pc_cur[7:0];
                  pc_save_r <= pc_cur;
                  flg_save_r <= flags_cur;
                  vec_r <= 8'(`PIL_VEC_BASE + {2'b00, win_src, 1'b0});
                  src_clr_r <= 26'(26'h1 << win_src) & `PIL_AUTO_CLR;
                  state_r <= ST_PUSH_PCH;
               end
            end
            ST_PUSH_PCH: begin
               stk_wdata_r <= pc_save_r[15:8];
               state_r <= ST_PUSH_FLG;
            end
            ST_PUSH_FLG: begin
               stk_wdata_r <= flg_save_r;
               state_r <= ST_FETCH_HI;
            end
            ST_FETCH_HI: begin
               stk_we_r <= 1'b0;
               rom_re_r <= 1'b1;
               rom_addr_r <= {8'h00, vec_r};
               state_r <= ST_FETCH_LO;
            end
            ST_FETCH_LO: begin
               rom_addr_r <= {8'h00, 8'(vec_r + 8'h01)};
               state_r <= ST_CAPT_HI;
            end
            ST_CAPT_HI: begin
               rom_re_r <= 1'b0;
               vec_hi_r <= rom_rdata;
               state_r <= ST_CAPT_LO;
            end
            ST_CAPT_LO: begin
               pc_target_r <= {vec_hi_r, rom_rdata};
               pc_load_r <= 1'b1;
               state_r <= ST_IDLE;
            end
            // The eighth state code is unused; fall back to idle if it ever shows.
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   assign sys_mode_rdata = system_mode_register_r;
   assign lvl_mask_rdata = level_mask_register_r;
   assign lvl_prio_rdata = level_priority_register_r;
   assign level_request = level_pend;
   assign stk_we = stk_we_r;
   assign stk_wdata = stk_wdata_r;
   assign rom_re = rom_re_r;
   assign rom_addr = rom_addr_r;
   assign src_clr = src_clr_r;
   assign pc_load = pc_load_r;
   assign pc_target = pc_target_r;
   assign busy = (state_r != ST_IDLE);

   sequence s_push;
      stk_we[*3] ##1 !stk_we;
   endsequence

   sequence s_fetch;
      !rom_re ##1 rom_re[*2] ##1 !rom_re;
   endsequence

   property p_grant_gie;
      @(posedge sys_clk) disable iff (srst) grant |=> !gie && !irq;
   endproperty
   a_grant_gie: assert property (p_grant_gie) else $error("grant left interrupts on");

   property p_push;
      @(posedge sys_clk) disable iff (srst)
         grant |=> (stk_wdata == $past(pc_cur[7:0])) and s_push;
   endproperty
   a_push: assert property (p_push) else $error("stack push sequence wrong");

   property p_fetch;
      @(posedge sys_clk) disable iff (srst) grant |-> ##3 s_fetch;
   endproperty
   a_fetch: assert property (p_fetch) else $error("vector fetch sequence wrong");

   property p_vec_load;
      @(posedge sys_clk) disable iff (srst)
         grant |-> ##7 pc_load && pc_target == {$past(rom_rdata, 2), $past(rom_rdata)};
   endproperty
   a_vec_load: assert property (p_vec_load) else $error("service address wrong");

   property p_vec_area;
      @(posedge sys_clk) disable iff (srst) rom_re |-> rom_addr[15:8] == 8'h00;
   endproperty
   a_vec_area: assert property (p_vec_area) else $error("vector outside low page");

   property p_boot;
      @(posedge sys_clk) $past(srst) && !srst |-> pc_load && pc_target == `PIL_RESET_PC;
   endproperty
   a_boot: assert property (p_boot) else $error("reset start address wrong");

   property p_ei;
      @(posedge sys_clk) disable iff (srst)
         enable_interrupts_instr && !disable_interrupts_instr && !grant |=> gie;
   endproperty
   a_ei: assert property (p_ei) else $error("enable instruction ignored");

   property p_di;
      @(posedge sys_clk) disable iff (srst) disable_interrupts_instr |=> !gie;
   endproperty
   a_di: assert property (p_di) else $error("disable instruction ignored");

   property p_masked;
      @(posedge sys_clk) disable iff (srst)
         (level_request & lvl_mask_rdata) == 8'h00 || !gie |-> !irq;
   endproperty
   a_masked: assert property (p_masked) else $error("masked request reached core");

   property p_lvl_pend;
      @(posedge sys_clk) disable iff (srst)
         (src_pend & src_en) == 26'h0 |-> level_request == 8'h00;
   endproperty
   a_lvl_pend: assert property (p_lvl_pend) else $error("level pending without source");

   property p_group_a;
      @(posedge sys_clk) disable iff (srst)
         lvl_prio_rdata[2:0] == 3'd0 && (act_lvl[1:0] != 2'b00) |->
            arb_if.win_valid && arb_if.win_lvl <= 3'd1;
   endproperty
   a_group_a: assert property (p_group_a) else $error("group order ignored");

   property p_auto_clr;
      @(posedge sys_clk) disable iff (srst)
         grant |=> src_clr == (26'(26'h1 << $past(win_src)) & `PIL_AUTO_CLR);
   endproperty
   a_auto_clr: assert property (p_auto_clr) else $error("source clear pulse wrong");

   property p_reset_sym;
      @(posedge sys_clk) $past(srst) |-> sys_mode_rdata == 2'b00;
   endproperty
   a_reset_sym: assert property (p_reset_sym) else $error("mode bits not cleared");
endmodule // pilic_ctrl
`default_nettype wire

// ---- core/pilic_defines.svh ----
`ifndef PILIC_DEFINES_SVH
`define PILIC_DEFINES_SVH

`define PIL_NUM_LVL 8
`define PIL_NUM_SRC 26
// First source index of each level, level 0 in the low five bits, end marker on top.
`define PIL_LVL_FIRST {5'd26, 5'd22, 5'd18, 5'd14, 5'd10, 5'd6, 5'd4, 5'd3, 5'd0}
`define PIL_VEC_BASE 8'hC0
`define PIL_RESET_PC 16'h0100
`define PIL_AUTO_CLR 26'h000FFFF
`define PIL_SYM_GIE 0
`define PIL_SYM_RST 2'h0
`define PIL_MASK_RST 8'h00
`define PIL_PRIO_RST 8'h00
`define PIL_PRIO_ORD_LSB 0
`define PIL_PRIO_SUBA 3
`define PIL_PRIO_SUBB 4
`define PIL_PRIO_SUBC 5
`define PIL_GRANT_TO_LOAD 7

`endif

// ---- core/pilic_pkg.sv ----
package pilic_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_PUSH_PCH, ST_PUSH_FLG, ST_FETCH_HI, ST_FETCH_LO, ST_CAPT_HI, ST_CAPT_LO
   } pilic_state_t;
   typedef logic [7:0] pilic_lvl_vec_t;
endpackage

// ---- tb/pilic_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pilic_cpu_model (
   input wire logic sys_clk, // Core clock.
   input wire logic srst, // Synchronous reset.
   input wire logic irq, // Request from the controller.
   input wire logic [1:0] ack_wait, // Cycles to wait before granting.
   output logic irq_ack, // Grant pulse.
   input wire logic rom_re, // Vector read strobe.
   input wire logic [15:0] rom_addr, // Vector read address.
   output logic [7:0] rom_rdata // Vector byte.
);
   logic [1:0] wait_r;
   function automatic logic [7:0] rom_byte(input logic [15:0] a);
      return a[7:0] * 8'h1D + 8'h37;
   endfunction
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_ack <= 1'h0;
         wait_r <= 2'h0;
      end else if (irq_ack) begin
         irq_ack <= 1'h0;
      end else if (irq) begin
         irq_ack <= (wait_r == ack_wait);
         wait_r <= (wait_r == ack_wait) ? 2'h0 : wait_r + 2'h1;
      end else begin
         wait_r <= 2'h0;
      end
   end
   // Outside a read the bus flips each cycle so a stale byte never looks valid.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rom_rdata <= 8'hA5;
      end else if (rom_re) begin
         rom_rdata <= rom_byte(rom_addr);
      end else begin
         rom_rdata <= ~rom_rdata;
      end
   end
endmodule // pilic_cpu_model
`default_nettype wire

// ---- tb/pilic_ctrl_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module pilic_ctrl_bench;
   import pilic_pkg::*;
   logic sys_clk, srst, sys_mode_wr, enable_interrupts_instr, disable_interrupts_instr;
   logic lvl_mask_wr, lvl_prio_wr, irq, irq_ack, stk_we, rom_re, pc_load, busy;
   logic [25:0] src_pend, src_en, src_clr;
   logic [1:0] sys_mode_wdata, sys_mode_rdata, ack_wait;
   logic [7:0] lvl_mask_wdata, lvl_mask_rdata, lvl_prio_wdata, lvl_prio_rdata, level_request;
   logic [7:0] flags_cur, stk_wdata, rom_rdata;
   logic [15:0] pc_cur, rom_addr, pc_target;
   logic [25:0] q_stk[$], q_rom[$], q_pc[$], q_clr[$];
   int miscompares, checks, cycles;
   integer seed;
   const int FIRST[9] = '{0, 3, 4, 6, 10, 14, 18, 22, 26};
   const int ORD[6][3] = '{'{0, 1, 2}, '{0, 2, 1}, '{1, 0, 2}, '{1, 2, 0}, '{2, 0, 1}, '{2, 1, 0}};

   pilic_ctrl u_dut (.sys_clk, .srst, .src_pend, .src_en, .sys_mode_wr, .sys_mode_wdata,
      .sys_mode_rdata, .enable_interrupts_instr, .disable_interrupts_instr, .lvl_mask_wr,
      .lvl_mask_wdata, .lvl_mask_rdata, .lvl_prio_wr, .lvl_prio_wdata, .lvl_prio_rdata,
      .level_request, .irq, .irq_ack, .pc_cur, .flags_cur, .stk_we, .stk_wdata, .rom_re,
      .rom_addr, .rom_rdata, .src_clr, .pc_load, .pc_target, .busy);
   pilic_cpu_model u_cpu (.sys_clk, .srst, .irq, .ack_wait, .irq_ack, .rom_re, .rom_addr,
      .rom_rdata);

   initial begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic check(input string what, input logic [25:0] exp, input logic [25:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic pop(ref logic [25:0] q[$], input string what, input logic [25:0] got);
      if (q.size() == 0) begin
         checks++;
         miscompares++;
         $display("BAD %s expected none seen %h", what, got);
      end else begin
         check(what, q.pop_front(), got);
      end
   endtask

   task automatic results;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic strobe(ref logic s);
      s = 1'h1;
      @(negedge sys_clk);
      s = 1'h0;
   endtask

   function automatic int winner(input logic [7:0] p, input logic [7:0] pr);
      int o, g, lo, hi, l;
      o = (pr[2:0] > 3'h5) ? 0 : int'(pr[2:0]);
      for (int i = 0; i < 3; i++) begin
         g = ORD[o][i];
         lo = (g == 0) ? 0 : ((g == 1) ? 2 : 5);
         hi = (g == 0) ? 1 : ((g == 1) ? 4 : 7);
         for (int k = 0; k <= hi - lo; k++) begin
            l = pr[3 + g] ? hi - k : lo + k;
            if (p[l]) return l;
         end
      end
      return -1;
   endfunction

   task automatic trial(input logic [7:0] prio);
      logic [25:0] act;
      logic [7:0] lr, msk;
      logic [15:0] vec;
      int lw, s;
      strobe(disable_interrupts_instr);
      msk = 8'($random(seed));
      lvl_mask_wdata = msk;
      strobe(lvl_mask_wr);
      lvl_prio_wdata = prio;
      strobe(lvl_prio_wr);
      src_pend = 26'($random(seed));
      src_en = 26'($random(seed));
      pc_cur = 16'($random(seed));
      flags_cur = 8'($random(seed));
      ack_wait = 2'($random(seed));
      act = src_pend & src_en;
      lr = 8'h00;
      for (int l = 0; l < 8; l++) for (int k = FIRST[l]; k < FIRST[l + 1]; k++) lr[l] |= act[k];
      @(negedge sys_clk);
      check("level request", 26'(lr), 26'(level_request));
      check("mask", 26'(msk), 26'(lvl_mask_rdata));
      check("priority", 26'(prio), 26'(lvl_prio_rdata));
      lw = winner(lr & msk, prio);
      if (lw >= 0) begin
         s = FIRST[lw];
         while (!act[s]) s++;
         vec = 16'h00C0 + 16'(2 * s);
         q_stk.push_back(26'(pc_cur[7:0]));
         q_stk.push_back(26'(pc_cur[15:8]));
         q_stk.push_back(26'(flags_cur));
         q_rom.push_back(26'(vec));
         q_rom.push_back(26'(vec + 16'h0001));
         q_pc.push_back(26'({u_cpu.rom_byte(vec), u_cpu.rom_byte(vec + 16'h0001)}));
         if (s < 16) q_clr.push_back(26'h1 << s);
      end
      strobe(enable_interrupts_instr);
      check("irq", 26'(lw >= 0), 26'(irq));
      if (lw >= 0) begin
         for (int t = 0; t < 30 && pc_load !== 1'h1; t++) @(negedge sys_clk);
         check("load seen", 26'h1, 26'(pc_load));
         check("global enable", 26'h0, 26'(sys_mode_rdata[0]));
         check("irq after grant", 26'h0, 26'(irq));
      end
      src_pend = 26'h0;
      @(negedge sys_clk);
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (!srst) begin
         if (stk_we === 1'h1) pop(q_stk, "stack byte", 26'(stk_wdata));
         if (stk_we === 1'h1) check("busy in push", 26'h1, 26'(busy));
         if (pc_load === 1'h1) check("busy at load", 26'h0, 26'(busy));
         if (rom_re === 1'h1) pop(q_rom, "vector address", 26'(rom_addr));
         if (pc_load === 1'h1) pop(q_pc, "pc target", 26'(pc_target));
         if (src_clr !== 26'h0) pop(q_clr, "source clear", src_clr);
      end
      if (cycles == 6000) begin
         miscompares++;
         results();
      end
   end

   initial begin
      seed = 32'hd3c4c901;
      {miscompares, checks, cycles} = '0;
      {sys_mode_wr, enable_interrupts_instr, disable_interrupts_instr} = 3'h0;
      {lvl_mask_wr, lvl_prio_wr, src_pend, src_en, sys_mode_wdata, ack_wait} = '0;
      {lvl_mask_wdata, lvl_prio_wdata, pc_cur, flags_cur} = '0;
      srst = 1'h1;
      q_pc.push_back(26'h0100);
      repeat (12) @(negedge sys_clk);
      srst = 1'h0;
      @(negedge sys_clk);
      check("mode after reset", 26'h0, 26'(sys_mode_rdata));
      sys_mode_wdata = 2'h3;
      strobe(sys_mode_wr);
      check("mode written", 26'h3, 26'(sys_mode_rdata));
      enable_interrupts_instr = 1'h1;
      disable_interrupts_instr = 1'h1;
      @(negedge sys_clk);
      {enable_interrupts_instr, disable_interrupts_instr} = 2'h0;
      check("mode di wins", 26'h2, 26'(sys_mode_rdata));
      strobe(enable_interrupts_instr);
      check("mode ei", 26'h3, 26'(sys_mode_rdata));
      sys_mode_wdata = 2'h0;
      strobe(sys_mode_wr);
      for (int n = 0; n < 80; n++) trial((8'($random(seed)) & 8'hF8) | 8'(n % 8));
      // A second reset with interrupts enabled must clear the mode bits and restart at boot.
      sys_mode_wdata = 2'h3;
      strobe(sys_mode_wr);
      srst = 1'h1;
      q_pc.push_back(26'h0100);
      repeat (2) @(negedge sys_clk);
      srst = 1'h0;
      @(negedge sys_clk);
      check("mode after second reset", 26'h0, 26'(sys_mode_rdata));
      check("mask after second reset", 26'h0, 26'(lvl_mask_rdata));
      repeat (4) @(negedge sys_clk);
      check("notes left", 26'h0,
         26'(q_stk.size() + q_rom.size() + q_pc.size() + q_clr.size()));
      results();
   end
endmodule // pilic_ctrl_bench
`default_nettype wire
